// [common/eams_pkg.sv]
// Package with register map, field layout, reset values and encodings of the accumulation mode block.
// How it works
// R1 - Reactive field 3:2 defaults 00, signed accumulation.
// R2 - Code 10 flips reactive sign when active negative.
// R3 - Reactive codes 01 and 11 act as 00.
// R4 - Wiring field 5:4; reactive uses quadrature current.
// R5 - Code 00: each phase own voltage, current.
// R6 - Code 01: phase B accumulators receive zero.
// R7 - Code 10: phase B voltage is minus(A+C).
// R8 - Code 11: phase B voltage is minus A.
// R9 - Bit 6 picks total/fundamental for reverse-active flags.
// R10 - Bit 7 picks total/fundamental for reverse-reactive flags.
// R11 - Active field 1:0: 11 absolute, else signed.
// R12 - New mode applies to later samples only.
package eams_pkg;
	localparam int unsigned EAMS_AW = 4;
	localparam logic [3:0] EAMS_ADDR_MODE = 4'h0;
	localparam logic [3:0] EAMS_ADDR_STATUS = 4'h1;
	localparam logic [3:0] EAMS_ADDR_CLEAR = 4'h2;
	localparam logic [3:0] EAMS_ADDR_ENABLE = 4'h3;
	localparam logic [7:0] EAMS_MODE_RESET = 8'h00;
	localparam int unsigned EAMS_ACT_LSB = 0;
	localparam int unsigned EAMS_REA_LSB = 2;
	localparam int unsigned EAMS_WIRE_LSB = 4;
	localparam int unsigned EAMS_REVA_BIT = 6;
	localparam int unsigned EAMS_REVR_BIT = 7;
	localparam int unsigned EAMS_FLAG_A_LSB = 6;
	localparam int unsigned EAMS_FLAG_R_LSB = 10;
	localparam logic [15:0] EAMS_STATUS_RESET = 16'h0000;
	localparam logic [1:0] EAMS_ACT_ABS = 2'h3;
	localparam logic [1:0] EAMS_REA_SIGNFOLLOW = 2'h2;
	typedef enum logic [1:0]
	{
		EAMS_WYE_3VS = 2'b00,
		EAMS_DELTA_3W = 2'b01,
		EAMS_WYE_2VS = 2'b10,
		EAMS_DELTA_4W = 2'b11
	} eams_wiring_e;
endpackage

// [logic/eams_top.sv]
// Accumulation mode selection: wiring, sign treatment and reverse-power flag sourcing per phase.
//
// The register offsets and the strobed register port were decided locally.
module eams_top
	import eams_pkg::*;
#(
	parameter int unsigned W = 24
)
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic resetn,
	// Register port.
	input wire logic [eams_pkg::EAMS_AW-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Sample strobe and instantaneous inputs (quadrature currents already shifted -90 degrees).
	input wire logic sample_valid,
	input wire logic signed [W-1:0] volt_a,
	input wire logic signed [W-1:0] volt_b,
	input wire logic signed [W-1:0] volt_c,
	input wire logic signed [W-1:0] curr_a,
	input wire logic signed [W-1:0] curr_b,
	input wire logic signed [W-1:0] curr_c,
	input wire logic signed [W-1:0] curr_q_a,
	input wire logic signed [W-1:0] curr_q_b,
	input wire logic signed [W-1:0] curr_q_c,
	input wire logic [W-1:0] vrms_a,
	input wire logic [W-1:0] vrms_b,
	input wire logic [W-1:0] vrms_c,
	input wire logic [W-1:0] irms_a,
	input wire logic [W-1:0] irms_b,
	input wire logic [W-1:0] irms_c,
	// Fundamental powers per phase, used for reverse flags and signed fundamental terms.
	input wire logic signed [2*W-1:0] fund_act_a,
	input wire logic signed [2*W-1:0] fund_act_b,
	input wire logic signed [2*W-1:0] fund_act_c,
	input wire logic signed [2*W-1:0] fund_rea_a,
	input wire logic signed [2*W-1:0] fund_rea_b,
	input wire logic signed [2*W-1:0] fund_rea_c,
	// Per-phase increments to the accumulators, index 0 = A, 1 = B, 2 = C.
	output logic inc_valid,
	output logic signed [2*W+1:0] act_inc [3],
	output logic signed [2*W+1:0] rea_inc [3],
	output logic [2*W-1:0] app_inc [3],
	output logic signed [2*W+1:0] fact_inc [3],
	output logic signed [2*W+1:0] frea_inc [3],
	// Interrupt.
	output logic irq
);
	import eams_pkg::*;

	localparam int unsigned PW = 2*W+2;

	logic [7:0] mode_ff, nxt_mode;
	logic [15:0] status_ff, nxt_status, enable_ff, nxt_enable, rdata_ff, nxt_rdata;
	logic inc_valid_ff, nxt_inc_valid;
	logic signed [PW-1:0] act_ff [3], nxt_act [3];
	logic signed [PW-1:0] rea_ff [3], nxt_rea [3];
	logic [2*W-1:0] app_ff [3], nxt_app [3];
	logic signed [PW-1:0] fact_ff [3], nxt_fact [3];
	logic signed [PW-1:0] frea_ff [3], nxt_frea [3];

	logic [1:0] act_mode, rea_mode;
	eams_wiring_e wiring;
	logic signed [W+1:0] vsel [3];
	logic signed [W+1:0] isel [3];
	logic signed [W+1:0] qsel [3];
	logic [W-1:0] vr [3];
	logic [W-1:0] ir [3];
	logic signed [2*W-1:0] fa [3];
	logic signed [2*W-1:0] fr [3];
	logic signed [PW-1:0] p_act [3];
	logic signed [PW-1:0] p_rea [3];
	logic signed [PW-1:0] p_fact [3];
	logic signed [PW-1:0] p_frea [3];
	logic [2:0] rev_act, rev_rea;

	// Mode fields decoded from the live register; a write lands before the next sample is taken.
	always_comb
	begin
		act_mode = mode_ff[EAMS_ACT_LSB +: 2];
		rea_mode = mode_ff[EAMS_REA_LSB +: 2];
		wiring = eams_wiring_e'(mode_ff[EAMS_WIRE_LSB +: 2]); // R4
	end

	// Input routing by wiring configuration, widened so the reconstructed sum cannot overflow.
	always_comb
	begin
		vsel[0] = (W+2)'(volt_a);
		vsel[2] = (W+2)'(volt_c);
		isel[0] = (W+2)'(curr_a);
		isel[1] = (W+2)'(curr_b);
		isel[2] = (W+2)'(curr_c);
		qsel[0] = (W+2)'(curr_q_a); // R4
		qsel[1] = (W+2)'(curr_q_b);
		qsel[2] = (W+2)'(curr_q_c);
		vr[0] = vrms_a;
		vr[1] = vrms_b;
		vr[2] = vrms_c;
		ir[0] = irms_a;
		ir[1] = irms_b;
		ir[2] = irms_c;
		fa[0] = fund_act_a;
		fa[1] = fund_act_b;
		fa[2] = fund_act_c;
		fr[0] = fund_rea_a;
		fr[1] = fund_rea_b;
		fr[2] = fund_rea_c;
		unique case (wiring)
			EAMS_WYE_3VS: vsel[1] = (W+2)'(volt_b); // R5
			EAMS_DELTA_3W: vsel[1] = '0; // R6
			EAMS_WYE_2VS: vsel[1] = -((W+2)'(volt_a) + (W+2)'(volt_c)); // R7
			EAMS_DELTA_4W: vsel[1] = -(W+2)'(volt_a); // R8
		endcase
	end

	// Signed products per phase; each factor is widened first, so the product keeps its upper bits.
	always_comb
	begin
		for (int k = 0; k < 3; k++)
		begin
			p_act[k] = PW'(vsel[k]) * PW'(isel[k]); // R5
			p_rea[k] = PW'(vsel[k]) * PW'(qsel[k]); // R4
			p_fact[k] = PW'(fa[k]);
			p_frea[k] = PW'(fr[k]);
		end
	end

	// Reverse detection uses the signed power before any absolute folding, so a rectified mode still reports.
	always_comb
	begin
		for (int k = 0; k < 3; k++)
		begin
			rev_act[k] = mode_ff[EAMS_REVA_BIT] ? p_fact[k][PW-1] : p_act[k][PW-1]; // R9
			rev_rea[k] = mode_ff[EAMS_REVR_BIT] ? p_frea[k][PW-1] : p_rea[k][PW-1]; // R10
		end
	end

	// Next increments: sign treatment by mode, phase B blanking, and a hold between samples.
	always_comb
	begin
		for (int k = 0; k < 3; k++)
		begin
			nxt_app[k] = vr[k] * ir[k]; // R5
			// In sign-follow mode each reactive power follows the sign of the active power of the same kind.
			if (rea_mode == EAMS_REA_SIGNFOLLOW)
			begin
				nxt_rea[k] = p_act[k][PW-1] ? -p_rea[k] : p_rea[k]; // R2
				nxt_frea[k] = p_fact[k][PW-1] ? -p_frea[k] : p_frea[k]; // R2
			end
			else
			begin
				nxt_rea[k] = p_rea[k]; // R1 R3
				nxt_frea[k] = p_frea[k]; // R1 R3
			end
			// Absolute mode folds both the total and the fundamental active power.
			if (act_mode == EAMS_ACT_ABS)
			begin
				nxt_act[k] = p_act[k][PW-1] ? -p_act[k] : p_act[k]; // R11
				nxt_fact[k] = p_fact[k][PW-1] ? -p_fact[k] : p_fact[k]; // R11
			end
			else
			begin
				nxt_act[k] = p_act[k]; // R11
				nxt_fact[k] = p_fact[k];
			end
			// Three-wire delta service has no phase B element, so all its increments are zero.
			if (wiring == EAMS_DELTA_3W && k == 1)
			begin
				nxt_app[k] = '0; // R6
				nxt_fact[k] = '0; // R6
				nxt_frea[k] = '0; // R6
			end
			// Between samples the increments stand, so a mode write never alters a past sample.
			if (!sample_valid)
			begin
				nxt_act[k] = act_ff[k]; // R12
				nxt_rea[k] = rea_ff[k]; // R12
				nxt_app[k] = app_ff[k];
				nxt_fact[k] = fact_ff[k];
				nxt_frea[k] = frea_ff[k];
			end
		end
	end

	// Sample marker, one cycle behind the strobe like the increments it qualifies.
	always_comb
	begin
		nxt_inc_valid = sample_valid;
	end

	// Sample marker register.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			inc_valid_ff <= 1'b0;
		else
			inc_valid_ff <= nxt_inc_valid;
	end

	// Increments are registered every cycle; the next-value logic holds them between samples.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int k = 0; k < 3; k++)
			begin
				act_ff[k] <= '0;
				rea_ff[k] <= '0;
				app_ff[k] <= '0;
				fact_ff[k] <= '0;
				frea_ff[k] <= '0;
			end
		end
		else
		begin
			for (int k = 0; k < 3; k++)
			begin
				act_ff[k] <= nxt_act[k]; // R12
				rea_ff[k] <= nxt_rea[k];
				app_ff[k] <= nxt_app[k];
				fact_ff[k] <= nxt_fact[k];
				frea_ff[k] <= nxt_frea[k];
			end
		end
	end

	// Next value of the mode and enable registers; a mode write applies from the next sample on.
	always_comb
	begin
		nxt_mode = mode_ff;
		nxt_enable = enable_ff;
		if (reg_wr && reg_addr == EAMS_ADDR_MODE)
			nxt_mode = reg_wdata[7:0]; // R12
		if (reg_wr && reg_addr == EAMS_ADDR_ENABLE)
			nxt_enable = reg_wdata;
	end

	// Mode and enable registers.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_ff <= EAMS_MODE_RESET; // R1
			enable_ff <= 16'h0000;
		end
		else
		begin
			mode_ff <= nxt_mode;
			enable_ff <= nxt_enable;
		end
	end

	// Next sticky status; setting after clearing lets an event in the clear cycle survive.
	always_comb
	begin
		nxt_status = status_ff;
		if (reg_wr && reg_addr == EAMS_ADDR_CLEAR)
			nxt_status = status_ff & ~reg_wdata;
		if (sample_valid)
		begin
			nxt_status[EAMS_FLAG_A_LSB +: 3] = nxt_status[EAMS_FLAG_A_LSB +: 3] | rev_act; // R9
			nxt_status[EAMS_FLAG_R_LSB +: 3] = nxt_status[EAMS_FLAG_R_LSB +: 3] | rev_rea; // R10
		end
	end

	// Status register.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			status_ff <= EAMS_STATUS_RESET;
		else
			status_ff <= nxt_status;
	end

	// Read data for the cycle after the strobe, zero otherwise and for unmapped or write-only indexes.
	always_comb
	begin
		nxt_rdata = 16'h0000;
		if (reg_rd)
		begin
			unique case (reg_addr)
				EAMS_ADDR_MODE: nxt_rdata = {8'h00, mode_ff};
				EAMS_ADDR_STATUS: nxt_rdata = status_ff;
				EAMS_ADDR_ENABLE: nxt_rdata = enable_ff;
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end

	// Read data register.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rdata_ff <= 16'h0000;
		else
			rdata_ff <= nxt_rdata;
	end

	// Register read data taken straight from a flip-flop; interrupt level is the OR of the enabled status flip-flops.
	assign reg_rdata = rdata_ff;
	assign irq = |(status_ff & enable_ff);

	// Sample marker and per-phase increments.
	assign inc_valid = inc_valid_ff;
	assign act_inc = act_ff;
	assign rea_inc = rea_ff;
	assign app_inc = app_ff;
	assign fact_inc = fact_ff;
	assign frea_inc = frea_ff;
endmodule // eams_top

// [tb/eams_sva.sv]
// Checker of sample increments and mode readback for the accumulation mode block.
module eams_sva
	import eams_pkg::*;
#(
	parameter int unsigned W = 24
)
(
	// Clock, reset and register port.
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [eams_pkg::EAMS_AW-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Samples and increments.
	input wire logic sample_valid,
	input wire logic signed [W-1:0] volt_a,
	input wire logic signed [W-1:0] curr_a,
	input wire logic signed [W-1:0] curr_q_a,
	input wire logic [W-1:0] vrms_b,
	input wire logic [W-1:0] irms_b,
	input wire logic inc_valid,
	input wire logic signed [2*W+1:0] act_inc [3],
	input wire logic signed [2*W+1:0] rea_inc [3],
	input wire logic [2*W-1:0] app_inc [3]
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mode_ff;
	logic signed [2*W+1:0] pa;
	logic signed [2*W+1:0] qa;
	logic [2*W-1:0] sb;
	// Shadow of the mode register, so that each sample is judged by the mode it was taken under.
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			mode_ff <= EAMS_MODE_RESET;
		else if (reg_wr && reg_addr == EAMS_ADDR_MODE)
			mode_ff <= reg_wdata[7:0];
	// Full-width products, so that no overflow hides a wrong sign.
	assign pa = volt_a * curr_a;
	assign qa = volt_a * curr_q_a;
	assign sb = vrms_b * irms_b;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_rd_mode;
		reg_rd && reg_addr == EAMS_ADDR_MODE;
	endsequence
	a_inc_pulse: assert property (inc_valid == $past(sample_valid))
		else $error("inc_valid off");
	a_act_plain: assert property (sample_valid && mode_ff[1:0] != EAMS_ACT_ABS |=> act_inc[0] == $past(pa))
		else $error("active increment wrong");
	a_act_abs: assert property (sample_valid && mode_ff[1:0] == EAMS_ACT_ABS |=> act_inc[0] == ($past(pa) < 0 ? -$past(pa) : $past(pa)))
		else $error("absolute increment wrong");
	a_rea_signed: assert property (sample_valid && mode_ff[3:2] != EAMS_REA_SIGNFOLLOW |=> rea_inc[0] == $past(qa))
		else $error("reactive increment wrong");
	a_rea_follow: assert property (sample_valid && mode_ff[3:2] == EAMS_REA_SIGNFOLLOW && pa < 0 |=> rea_inc[0] == -$past(qa))
		else $error("reactive sign not flipped");
	a_b_zero: assert property (sample_valid && mode_ff[5:4] == EAMS_DELTA_3W |=> act_inc[1] == 0 && rea_inc[1] == 0 && app_inc[1] == 0)
		else $error("phase B not zero");
	a_b_app: assert property (sample_valid && mode_ff[5:4] != EAMS_DELTA_3W |=> app_inc[1] == $past(sb))
		else $error("phase B apparent wrong");
	a_rd_mode: assert property (s_rd_mode |=> reg_rdata == {8'h00, $past(mode_ff)})
		else $error("mode readback wrong");
endmodule // eams_sva
bind eams_top eams_sva #(.W(W)) eams_sva_inst (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .sample_valid, .volt_a, .curr_a, .curr_q_a, .vrms_b, .irms_b, .inc_valid, .act_inc, .rea_inc, .app_inc);

// [tb/eams_top_test.sv]
// Testbench of the accumulation mode block.
module eams_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import eams_pkg::*;
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	logic [3:0] reg_addr = '0;
	logic [15:0] reg_wdata = '0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [15:0] reg_rdata;
	logic sample_valid = 1'h0;
	logic signed [23:0] v = '0;
	logic signed [23:0] i = '0;
	logic signed [23:0] q = '0;
	logic signed [47:0] fa = '0;
	logic signed [47:0] fr = '0;
	logic inc_valid;
	logic irq;
	logic signed [49:0] act [3];
	logic signed [49:0] rea [3];
	logic [47:0] app [3];
	logic signed [49:0] fact [3];
	logic signed [49:0] frea [3];
	logic signed [49:0] vb;
	int n_errors = 0;
	int checks_done = 0;
	// Phase B sees q as voltage and phase C sees i, so every wiring code gives a distinct result.
	eams_top eams_top_inst (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid,
		.volt_a(v), .volt_b(q), .volt_c(i), .curr_a(i), .curr_b(i), .curr_c(i), .curr_q_a(q), .curr_q_b(q),
		.curr_q_c(q), .vrms_a(v), .vrms_b(v), .vrms_c(v), .irms_a(i), .irms_b(i), .irms_c(i), .fund_act_a(fa),
		.fund_act_b(fa), .fund_act_c(fa), .fund_rea_a(fr), .fund_rea_b(fr), .fund_rea_c(fr), .inc_valid,
		.act_inc(act), .rea_inc(rea), .app_inc(app), .fact_inc(fact), .frea_inc(frea), .irq);
	// Free-running clock at 50 ns.
	initial
		forever #25 core_clk = ~core_clk;
	task automatic chk(input logic [49:0] g, input logic [49:0] x);
		checks_done++;
		if (g !== x)
			n_errors++;
		if (g !== x)
			$display("unexpected at %0t: got %h want %h", $time, g, x);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	// The read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic rd(input logic [3:0] a, input logic [15:0] x);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, x);
	endtask
	task automatic smp(input logic signed [23:0] a, b, c, input logic signed [47:0] f, g);
		@(posedge core_clk);
		v <= a;
		i <= b;
		q <= c;
		fa <= f;
		fr <= g;
		sample_valid <= 1'h1;
		@(posedge core_clk);
		sample_valid <= 1'h0;
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence: reset values, wiring codes, sign codes, reverse flags and interrupt.
	initial
	begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'h1;
		rd(EAMS_ADDR_MODE, 16'h0000);
		rd(4'hF, 16'h0000);
		rd(EAMS_ADDR_STATUS, 16'h0000);
		for (int k = 0; k < 4; k++)
		begin
			wr(EAMS_ADDR_MODE, 16'(k << 4));
			rd(EAMS_ADDR_MODE, 16'(k << 4));
			smp(24'sh5, 24'sh3, 24'sh7, 48'sh2, 48'sh6);
			chk(fact[1], k == 1 ? 50'h0 : 50'h2);
			chk(frea[1], k == 1 ? 50'h0 : 50'h6);
			vb = k == 0 ? 50'sh7 : k == 1 ? 50'sh0 : k == 2 ? -50'sh8 : -50'sh5;
			chk(act[1], vb * i);
			chk(rea[1], vb * q);
			chk(app[1], k == 1 ? 50'h0 : 50'hF);
		end
		for (int k = 0; k < 4; k++)
		begin
			wr(EAMS_ADDR_MODE, 16'(k * 5));
			smp(24'sh5, -24'sh3, 24'sh7, -48'sh4, 48'sh9);
			chk(fact[0], k == 3 ? 50'sh4 : -50'sh4);
			chk(frea[0], k == 2 ? -50'sh9 : 50'sh9);
			chk(act[0], k == 3 ? 50'shF : -50'shF);
			chk(rea[0], k == 2 ? -50'sh23 : 50'sh23);
		end
		wr(EAMS_ADDR_ENABLE, 16'h1DC0);
		for (int s = 0; s < 2; s++)
		begin
			wr(EAMS_ADDR_MODE, s ? 16'h00C0 : 16'h0000);
			wr(EAMS_ADDR_CLEAR, 16'hFFFF);
			smp(24'sh5, -24'sh3, -24'sh7, 48'sh1, 48'sh1);
			rd(EAMS_ADDR_STATUS, s ? 16'h0000 : 16'h0440);
			chk(irq, s == 0);
			smp(24'sh5, 24'sh3, 24'sh7, -48'sh1, -48'sh1);
			rd(EAMS_ADDR_STATUS, s ? 16'h1DC0 : 16'h0440);
		end
		wr(EAMS_ADDR_ENABLE, 16'h0000);
		#1 chk(irq, 1'h0);
		wr(EAMS_ADDR_ENABLE, 16'h1DC0);
		#1 chk(irq, 1'h1);
		wr(EAMS_ADDR_CLEAR, 16'hFFFF);
		#1 chk(irq, 1'h0);
		rd(EAMS_ADDR_CLEAR, 16'h0000);
		rd(EAMS_ADDR_STATUS, 16'h0000);
		summarize();
	end
endmodule // eams_top_test
